// ===== rtl/eeprom_program_protect_ctrl.sv
// EEPROM program/erase sequencer with protect and readout lock options.
// Assumes an APB master on clk; stop/wait/boot/test requests arrive as pins.
//
// Overview of operation
// - Array access fails during an operation.
// - Other addresses ignored once address latched.
// - Options byte loaded into latches at reset.
// - Reset leaves stored option bits untouched.
// - Lower 32 bytes never protected.
// - Protect bit zero blocks upper area writes.
// - Erased protect takes effect after reset.
// - Protect zero accepted only while latched.
// - Lock bit zero refuses test mode.
// - Bootstrap entry erases whole EEPROM.
// - Lock change waits for next reset.
// - Stop forces read mode, pump off.
// - Wait mode leaves operation untouched.
// - Latch clear forces erase, pump zero.
// - Array reads all ones while latched.
// - Erase writes ones, program clears bits.
// - Pump sets after capture, clears via latch.
//
// Our own choice: the APB slave port.
module eeprom_program_protect_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int program_count = program_cycles,
    parameter int erase_count = erase_cycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_req,
    input wire logic wait_req,
    input wire logic boot_req,
    input wire logic test_req,
    output logic test_mode,
    output logic pump_active
);
    import eeprom_ctrl_pkg::*;
    initial begin
        if (program_count < 1 || erase_count < 1) $error("counts must be positive");
    end
    typedef struct packed {
        seq_type seq;
        logic erase_sel;
        logic [7:0] addr;
        logic [7:0] data;
        logic protect_lat;
        logic lock_lat;
        logic load;
        logic booted;
        logic test;
        logic [31:0] rdata;
        logic err;
    } st_type;
    st_type s_q, s_d;
    // Cells leave the factory erased; contents survive every reset
    logic [7:0] mem_q [array_depth] = '{default: erased_byte};
    logic stop_s, boot_s, test_s;
    logic hv_done;
    logic wr_en;
    logic [7:0] widx;
    logic [7:0] wval;
    logic [7:0] wlo;
    logic [7:0] ctrl_rd;
    logic [7:0] optv;
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    sync2 u_stop (.clk(clk), .rstn(rstn), .din(stop_req), .dout(stop_s));
    sync2 u_boot (.clk(clk), .rstn(rstn), .din(boot_req), .dout(boot_s));
    sync2 u_test (.clk(clk), .rstn(rstn), .din(test_req), .dout(test_s));
    // Wait mode is deliberately not used: nothing here stalls in wait
    logic wait_unused;
    assign wait_unused = wait_req;
    // ****************************************************************
    // High-voltage timer
    // ****************************************************************
    hv_timer #(.count_max(program_count)) u_timer (
        .clk(clk), .rstn(rstn),
        .run(s_q.seq == st_burn),
        .limit(s_q.erase_sel ? 32'(erase_count) : 32'(program_count)),
        .done(hv_done)
    );
    function automatic logic in_array(input logic [11:0] a);
        in_array = (a >= array_base) && (a <= array_last);
    endfunction
    function automatic logic [7:0] arr_idx(input logic [11:0] a);
        arr_idx = a[9:2];
    endfunction
    // Any address that answers a read without an error
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = in_array(a) || a == ctrl_addr || a == stat_addr || a == mode_addr;
    endfunction
    assign optv = mem_q[option_index];
    assign wlo = pwdata[7:0];
    assign ctrl_rd = {5'b0_0000, s_q.erase_sel, s_q.seq != st_read, s_q.seq == st_burn};
    // ****************************************************************
    // Sequencer and registers
    // ****************************************************************
    always_comb begin
        logic acc;
        logic setup;
        logic latched;
        acc = psel && penable;
        setup = psel && !penable;
        latched = s_q.seq != st_read;
        s_d = s_q;
        s_d.load = 1'b0;
        wr_en = 1'b0;
        widx = s_q.addr;
        wval = s_q.data;
        // Latches copy the stored options one cycle after reset
        if (s_q.load) begin
            s_d.protect_lat = optv[protect_bit];
            s_d.lock_lat = optv[lock_bit];
        end
        if (acc && pwrite && pstrb[0]) begin
            if (paddr == ctrl_addr) begin
                if (!wlo[latch_bit]) begin
                    s_d.seq = st_read;
                    s_d.erase_sel = 1'b0;
                end else if (s_q.seq == st_read || s_q.seq == st_load) begin
                    s_d.seq = st_load;
                    s_d.erase_sel = wlo[erase_bit]; // Frozen once address latched
                end else if (s_q.seq == st_armed && wlo[pump_bit]) begin
                    s_d.seq = st_burn;
                end
            end else if (in_array(paddr)) begin
                if (s_q.seq == st_load) begin
                    s_d.addr = arr_idx(paddr);
                    s_d.data = wlo;
                    s_d.seq = st_armed;
                end
            end
        end
        // Commit when the pump time has elapsed and latch is cleared
        if (s_q.seq == st_burn && s_d.seq == st_read && hv_done) begin
            if (s_q.addr >= upper_first && !s_q.protect_lat) begin
                wr_en = 1'b0;
            end else if (s_q.addr == option_index && !s_q.erase_sel &&
                         !s_q.data[protect_bit]) begin
                wr_en = 1'b1;
            end else begin
                wr_en = 1'b1;
            end
        end
        if (stop_s) begin
            s_d.seq = st_read;
            s_d.erase_sel = 1'b0;
        end
        if (boot_s && !s_q.booted) begin
            s_d.booted = 1'b1;
        end
        s_d.test = test_s && s_q.lock_lat;
        // Answer is decided in the setup cycle, so data and error already
        // stand at the edge where the master samples pready; held until
        // the next setup cycle
        if (setup) begin
            s_d.rdata = 32'h0000_0000;
            s_d.err = 1'b0;
            if (pwrite) begin
                if (pstrb[0] && in_array(paddr) && s_q.seq != st_load) begin
                    s_d.err = 1'b1;
                end else if (pstrb[0] && !in_array(paddr) && paddr != ctrl_addr &&
                             paddr != mode_addr) begin
                    s_d.err = 1'b1;
                end
            end else if (!reg_hit(paddr)) begin
                s_d.err = 1'b1;
            end else if (paddr == ctrl_addr) begin
                s_d.rdata = {24'h00_0000, ctrl_rd};
            end else if (paddr == stat_addr) begin
                s_d.rdata = {27'h000_0000, s_q.test, s_q.seq == st_armed,
                             s_q.seq == st_burn, s_q.protect_lat, s_q.lock_lat};
            end else if (paddr == mode_addr) begin
                s_d.rdata = {29'h0000_0000, test_s, boot_s, stop_s};
            end else if (in_array(paddr)) begin
                s_d.rdata = latched ? {24'h00_0000, blank_read}
                                    : {24'h00_0000, mem_q[arr_idx(paddr)]};
            end
        end
    end
    // ****************************************************************
    // State and array registers
    // ****************************************************************
    // Reset clears control only; array cells keep their contents
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.load <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    always_ff @(posedge clk) begin
        if (rstn && boot_s && !s_q.booted) begin
            for (int i = 0; i < array_depth; i++) begin
                mem_q[i] <= erased_byte;
            end
        end else if (rstn && wr_en) begin
            // Erase sets all ones; program only clears bits
            mem_q[widx] <= s_q.erase_sel ? erased_byte : (mem_q[widx] & wval);
        end
    end
    // ****************************************************************
    // Outputs
    // ****************************************************************
    // No wait states: data and error were loaded in the setup cycle
    assign pready = psel && penable;
    assign prdata = s_q.rdata;
    assign pslverr = s_q.err && pready; // Error only shown with the answer
    assign test_mode = s_q.test;
    assign pump_active = s_q.seq == st_burn;
    // ****************************************************************
    // Checks
    // ****************************************************************
    a_latch_clear_pump: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl_rd[latch_bit] == 1'b0) |-> (ctrl_rd[pump_bit] == 1'b0 &&
        ctrl_rd[erase_bit] == 1'b0)) else $error("pump on without latch");
    a_stop_read_mode: assert property (@(posedge clk) disable iff (!rstn)
        stop_s |=> (s_q.seq == st_read)) else $error("stop left latch");
    a_lock_no_test: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.lock_lat |=> !test_mode) else $error("test entered while locked");
    a_pump_after_cap: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pump_active) |-> $past(s_q.seq) == st_armed) else $error("pump early");
    a_upper_protect: assert property (@(posedge clk) disable iff (!rstn)
        wr_en |-> (s_q.protect_lat || widx < upper_first)) else $error("protect");
    a_latched_reads_ff: assert property (@(posedge clk) disable iff (!rstn)
        (psel && !penable && !pwrite && in_array(paddr) && s_q.seq != st_read)
        |=> prdata == {24'h00_0000, blank_read}) else $error("latched read not ones");
    a_second_addr: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.seq == st_armed && psel && penable && pwrite && in_array(paddr))
        |=> $stable(s_q.addr)) else $error("second address taken");
    a_reset_loads: assert property (@(posedge clk)
        !rstn ##1 rstn |=> s_q.protect_lat == $past(optv[protect_bit]))
        else $error("options not loaded");
    // Array writes during a burn are refused at the answer
    a_busy_write_err: assert property (@(posedge clk) disable iff (!rstn)
        (psel && !penable && pwrite && pstrb[0] && in_array(paddr) && s_q.seq == st_burn)
        |=> pslverr) else $error("array write taken while busy");
    // Erase select frozen once the address is captured
    a_erase_frozen: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.seq == st_armed || s_q.seq == st_burn)
        |=> (s_q.seq == st_read || $stable(s_q.erase_sel))) else $error("erase select moved");
    // Lower area commits whatever the protect latch says
    a_lower_writable: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.seq == st_burn && s_d.seq == st_read && hv_done && s_q.addr < upper_first)
        |-> wr_en) else $error("lower area refused");
    // Bootstrap entry leaves the options byte erased
    a_boot_wipes: assert property (@(posedge clk) disable iff (!rstn)
        (boot_s && !s_q.booted) |=> (mem_q[option_index] == erased_byte))
        else $error("boot left array");
    // Test mode only follows a request seen on the pin
    a_test_needs_pin: assert property (@(posedge clk) disable iff (!rstn)
        test_mode |-> $past(test_s)) else $error("test mode without request");
    // Pump is off the cycle after stop is seen
    a_stop_pump_off: assert property (@(posedge clk) disable iff (!rstn)
        stop_s |=> !pump_active) else $error("pump on in stop");
endmodule // eeprom_program_protect_ctrl

// ===== rtl/eeprom_ctrl_pkg.sv
// Package for the byte-wise EEPROM program/erase controller.
// Assumes a 32-bit APB slave, word aligned registers, one 100 MHz clock.
package eeprom_ctrl_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ctrl_addr = 12'h01C;        // Control word, index 0x7
    localparam logic [11:0] mode_addr = 12'h020;        // Synchronised stop/boot/test pin levels
    localparam logic [11:0] stat_addr = 12'h024;        // Latched options and busy
    localparam logic [11:0] array_base = 12'h400;       // Array word 0 = location 0x100
    localparam logic [11:0] array_last = 12'h7FC;
    // ****************************************************************
    // Array layout
    // ****************************************************************
    localparam int array_depth = 256;
    localparam logic [7:0] option_index = 8'h00;        // Options byte at 0x100
    localparam logic [7:0] upper_first = 8'h20;         // 0x120 starts protected area
    localparam logic [7:0] erased_byte = 8'hFF;
    localparam logic [7:0] blank_read = 8'hFF;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int pump_bit = 0;
    localparam int latch_bit = 1;
    localparam int erase_bit = 2;
    localparam int protect_bit = 1;
    localparam int lock_bit = 0;
    localparam int stop_bit = 0;
    localparam int boot_bit = 1;
    localparam int test_bit = 2;
    localparam int busy_bit = 2;
    localparam int armed_bit = 3;
    localparam int testmode_bit = 4;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int clk_mhz = 100;
    localparam int program_time_us = 10000;             // Chosen default, ms range
    localparam int erase_time_us = 10000;
    localparam int program_cycles = program_time_us * clk_mhz;
    localparam int erase_cycles = erase_time_us * clk_mhz;
    typedef enum logic [1:0] {
        st_read = 2'b00,
        st_load = 2'b01,
        st_armed = 2'b10,
        st_burn = 2'b11
    } seq_type;
endpackage : eeprom_ctrl_pkg

// ===== rtl/hv_timer.sv
// Counts the high-voltage time while the pump runs; reports done.
// Assumes run is a level from logic on the same clock.
module hv_timer #(
    parameter int count_max = 1000000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [31:0] limit,
    output logic done
);
    initial begin
        if (count_max < 1) $error("count_max must be positive");
    end
    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } st_type;
    st_type s_q, s_d;
    // ****************************************************************
    // Counter
    // ****************************************************************
    // Counting stops at limit; pump stays on until software clears latch
    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.cnt = 32'h0000_0000;
            s_d.done = 1'b0;
        end else if (s_q.cnt + 32'h0000_0001 >= limit) begin
            s_d.done = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done = s_q.done;
endmodule // hv_timer

// ===== rtl/sync2.sv
// Two flip-flop synchroniser for a level from a pin.
// Assumes the pin is asynchronous to clk.
module sync2 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic ff1;
        logic ff2;
    } st_type;
    st_type s_q, s_d;
    // ****************************************************************
    // Stages
    // ****************************************************************
    // First stage is read only by the second
    always_comb begin
        s_d.ff1 = din;
        s_d.ff2 = s_q.ff1;
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign dout = s_q.ff2;
endmodule // sync2

// ===== dv/eeprom_program_protect_ctrl_test.sv
// Self-checking bench for the EEPROM program/erase controller.
// Assumes an APB slave; the master waits for pready and takes data at that edge.
module eeprom_program_protect_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    import eeprom_ctrl_pkg::*;

    // ****************************************************************
    // Signals and design under test
    // ****************************************************************
    localparam int pc = 20;    // Shortened high-voltage time keeps the run brief
    logic clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] pstrb;
    logic stop_req, wait_req, boot_req, test_req, test_mode, pump_active, err_q;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    eeprom_program_protect_ctrl #(.program_count(pc), .erase_count(pc)) uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
        .wait_req(wait_req), .boot_req(boot_req), .test_req(test_req),
        .test_mode(test_mode), .pump_active(pump_active));

    // Clock and hang guard; the ceiling is far above the planned sequence
    // Pump timing runs off the core clock, no RC source in this bench
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
        check_count++;
        if (seen !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One APB transfer; data and error are taken at the edge pready is high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd_q[7:0], e);
    endtask

    function automatic logic [11:0] loc(input logic [7:0] i);
        return array_base + {2'h0, i, 2'h0};
    endfunction

    // Full latch, load, pump, wait, unlatch sequence on one location
    task automatic op(input logic [7:0] i, input logic [7:0] d, input logic era);
        apb(1'b1, ctrl_addr, {29'h0000_0000, era, 2'h2});
        apb(1'b1, loc(i), {24'h00_0000, d});
        apb(1'b1, ctrl_addr, {29'h0000_0000, era, 2'h3});
        repeat (pc + 10) @(posedge clk);
        apb(1'b1, ctrl_addr, 32'h0000_0000);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        tick(3);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, stop_req, wait_req, boot_req, test_req} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        do_reset();
        rd("ctrl_reset", ctrl_addr, 8'h00);
        // Blank the options byte so both latches come up set
        op(8'h00, 8'h00, 1'b1);
        rd("option_erased", loc(8'h00), erased_byte);
        do_reset();
        apb(1'b0, stat_addr, 32'h0000_0000);
        chk("stat_options", {6'h00, rd_q[1:0]}, 8'h03);
        rd("option_kept", loc(8'h00), erased_byte);
        // Pump refused before capture, then held until unlatch; latch low clears all
        apb(1'b1, ctrl_addr, 32'h0000_0003);
        rd("ctrl_no_pump", ctrl_addr, 8'h02);
        apb(1'b1, loc(8'h04), 32'h0000_0000);
        apb(1'b1, ctrl_addr, 32'h0000_0003);
        apb(1'b1, ctrl_addr, 32'h0000_0002);
        rd("ctrl_pump_held", ctrl_addr, 8'h03);
        repeat (pc + 10) @(posedge clk);
        apb(1'b1, ctrl_addr, 32'h0000_0005);
        rd("ctrl_read_cond", ctrl_addr, 8'h00);
        // Erase in wait mode; array refuses access while the pump runs
        apb(1'b1, ctrl_addr, 32'h0000_0006);
        apb(1'b1, loc(8'h04), 32'h0000_0000);
        apb(1'b1, ctrl_addr, 32'h0000_0007);
        wait_req <= 1'b1;
        tick(3);
        chk("pump_in_wait", {7'h00, pump_active}, 8'h01);
        apb(1'b1, loc(8'h03), 32'h0000_0000);
        chk("busy_write_err", {7'h00, err_q}, 8'h01);
        rd("busy_read", loc(8'h04), blank_read);
        repeat (pc) @(posedge clk);
        apb(1'b1, ctrl_addr, 32'h0000_0000);
        wait_req <= 1'b0;
        rd("erase_in_wait", loc(8'h04), erased_byte);
        // Second address after capture is refused and left alone
        apb(1'b1, ctrl_addr, 32'h0000_0002);
        apb(1'b1, loc(8'h01), 32'h0000_0000);
        apb(1'b1, loc(8'h02), 32'h0000_0000);
        chk("second_addr_err", {7'h00, err_q}, 8'h01);
        apb(1'b1, ctrl_addr, 32'h0000_0003);
        repeat (pc + 10) @(posedge clk);
        apb(1'b1, ctrl_addr, 32'h0000_0000);
        rd("second_addr", loc(8'h02), erased_byte);
        rd("programmed", loc(8'h01), 8'h00);
        // Upper area open while protect latch is set
        op(8'h20, 8'h00, 1'b1);
        op(8'h20, 8'h5A, 1'b0);
        rd("upper_prog", loc(8'h20), 8'h5A);
        // Clear protect; latches follow only after reset
        op(8'h00, 8'h01, 1'b0);
        apb(1'b0, stat_addr, 32'h0000_0000);
        chk("stat_no_reload", {6'h00, rd_q[1:0]}, 8'h03);
        do_reset();
        apb(1'b0, stat_addr, 32'h0000_0000);
        chk("stat_protected", {6'h00, rd_q[1:0]}, 8'h01);
        rd("option_reset", loc(8'h00), 8'h01);
        op(8'h20, 8'h00, 1'b1);
        rd("upper_locked", loc(8'h20), 8'h5A);
        op(8'h01, 8'h00, 1'b1);
        rd("lower_open", loc(8'h01), erased_byte);
        op(8'h00, 8'h00, 1'b1);
        apb(1'b0, stat_addr, 32'h0000_0000);
        chk("protect_persists", {6'h00, rd_q[1:0]}, 8'h01);
        do_reset();
        apb(1'b0, stat_addr, 32'h0000_0000);
        chk("protect_released", {6'h00, rd_q[1:0]}, 8'h03);
        // Readout lock gates test mode; bootstrap wipes the array
        test_req <= 1'b1;
        tick(6);
        chk("test_open", {7'h00, test_mode}, 8'h01);
        op(8'h00, 8'h02, 1'b0);
        chk("lock_deferred", {7'h00, test_mode}, 8'h01);
        do_reset();
        tick(6);
        chk("test_refused", {7'h00, test_mode}, 8'h00);
        boot_req <= 1'b1;
        tick(300);
        rd("boot_wipe_opt", loc(8'h00), erased_byte);
        rd("boot_wipe_upper", loc(8'h20), erased_byte);
        boot_req <= 1'b0;
        do_reset();
        tick(6);
        chk("test_after_boot", {7'h00, test_mode}, 8'h01);
        test_req <= 1'b0;
        // Stop mid-erase drops the pump and returns to read mode
        apb(1'b1, ctrl_addr, 32'h0000_0006);
        apb(1'b1, loc(8'h03), 32'h0000_0000);
        apb(1'b1, ctrl_addr, 32'h0000_0007);
        stop_req <= 1'b1;
        tick(6);
        chk("stop_pump", {7'h00, pump_active}, 8'h00);
        rd("stop_ctrl", ctrl_addr, 8'h00);
        stop_req <= 1'b0;
        // Unmapped address
        apb(1'b0, 12'h030, 32'h0000_0000);
        chk("unmapped_err", {7'h00, err_q}, 8'h01);
        summarize();
    end
endmodule // eeprom_program_protect_ctrl_test
